/* File: pdio_pkg.sv */
/*
 * Package for the discrete PLC I/O block: register map, field layouts,
 * reset values, function codes and timing counts.
 * Assumes a 25 MHz system clock.
 */
package pdio_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ = 25_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
    localparam int unsigned SAMPLE_MIN_MS = 10;
    localparam int unsigned SAMPLE_MAX_MS = 100;
    localparam int unsigned VENT_RST_MS = 2000;
    localparam int unsigned NUM_IN = 3;
    localparam int unsigned NUM_RELAY = 4;

    // Register byte offsets
    localparam logic [7:0] REG_LOC = 8'h00;
    localparam logic [7:0] REG_SAMPLE = 8'h04;
    localparam logic [7:0] REG_VENT = 8'h08;
    localparam logic [7:0] REG_INMAP = 8'h0C;
    localparam logic [7:0] REG_OUTMAP = 8'h10;
    localparam logic [7:0] REG_SERIAL = 8'h14;
    localparam logic [7:0] REG_REC = 8'h18;
    localparam logic [7:0] REG_STATUS = 8'h1C;

    // Reset values
    localparam logic [2:0] LOC_RST = 3'h5;
    localparam logic [6:0] SAMPLE_RST = 7'h0A;
    localparam logic [15:0] VENT_RST = 16'h07D0;
    localparam logic [8:0] INMAP_RST = 9'h0D1;
    localparam logic [15:0] OUTMAP_RST = 16'h2810;
    localparam logic [8:0] SERIAL_RST = 9'h004;
    localparam logic [10:0] REC_RST = 11'h005;

    // Field positions
    localparam int unsigned IN_FW = 3;
    localparam int unsigned OUT_FW = 4;
    localparam int unsigned REC_FN_LSB = 0;
    localparam int unsigned REC_STEP_LSB = 3;
    localparam int unsigned REC_DEC_LSB = 6;

    // Control location
    typedef enum logic [2:0] {
        LOC_PLC = 3'h0, LOC_SER = 3'h1, LOC_ALL = 3'h2,
        LOC_LCL_PLC = 3'h3, LOC_LCL_SER = 3'h4, LOC_LCL = 3'h5
    } pdio_loc_e;

    // Command input functions
    typedef enum logic [2:0] {
        IN_ZERO = 3'h0, IN_START = 3'h1, IN_STOP = 3'h2, IN_PURGE = 3'h3,
        IN_CLEAR = 3'h4, IN_CAL = 3'h5, IN_CAL_INT = 3'h6, IN_CAL_EXT = 3'h7
    } pdio_infn_e;

    // Relay functions
    typedef enum logic [3:0] {
        OUT_TRIG1 = 4'h0, OUT_ZERO = 4'h1, OUT_READY = 4'h2,
        OUT_CAL_ACT = 4'h3, OUT_CAL_REQ = 4'h4, OUT_FAIL = 4'h5,
        OUT_WARN = 4'h6, OUT_GASB = 4'h7, OUT_OPEN = 4'h8,
        OUT_CLOSE = 4'h9, OUT_STROBE = 4'hA, OUT_PUMP = 4'hB,
        OUT_STANDBY = 4'hC, OUT_VENTED = 4'hD, OUT_EMIS = 4'hE
    } pdio_outfn_e;

    // Recorder functions
    typedef enum logic [2:0] {
        REC_OFF = 3'h0, REC_P1 = 3'h1, REC_P2 = 3'h2, REC_MANT = 3'h3,
        REC_EXP = 3'h4, REC_LIN = 3'h5, REC_LOG = 3'h6
    } pdio_recfn_e;

    localparam logic [2:0] STEP_MAX = 3'h5;
    localparam logic [2:0] BAUD_MAX = 3'h4;
    localparam logic [1:0] TERM_MAX = 2'h2;
    localparam logic [1:0] PAR_MAX = 2'h2;

    // Machine state seen by the block
    typedef struct packed {
        logic measuring;
        logic standby;
        logic vent_mode;
        logic emission;
        logic error;
        logic warning;
        logic trig1_over;
        logic rec_invalid;
        logic pumping;
        logic cal_running;
        logic cal_request;
        logic gas_ballast;
    } pdio_mach_s;

    // Command pulses and levels toward the machine
    typedef struct packed {
        logic start;
        logic stop;
        logic vent;
        logic error_ack;
        logic cal_int;
        logic cal_ext;
        logic cal_confirm;
        logic zero_en;
        logic purge_en;
    } pdio_cmd_s;

    // Serial framing settings
    typedef struct packed {
        logic [2:0] baud;
        logic [1:0] term;
        logic eight_bits;
        logic [1:0] parity;
        logic two_stop;
    } pdio_ser_s;

endpackage

/* File: pdio_sampler.sv */
/*
 * Command input sampler: two-flop synchroniser per pin, then one sample
 * per strobe and edge detection against the previous sample.
 * Assumes the strobe is a one-cycle pulse on sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none
module pdio_sampler
    import pdio_pkg::*;
(
    input wire logic sys_clk_i,              // System clock
    input wire logic rstn_i,                 // Sync reset, active low
    input wire logic [NUM_IN-1:0] pin_i,     // Raw command pins
    input wire logic strobe_i,               // Sample strobe
    output logic [NUM_IN-1:0] level_o,       // Current sample
    output logic [NUM_IN-1:0] rise_o,        // Rising edge pulse
    output logic [NUM_IN-1:0] fall_o         // Falling edge pulse
);

    logic [NUM_IN-1:0] sync_a;
    logic [NUM_IN-1:0] sync_b;
    logic [NUM_IN-1:0] prev;

    ////////////////////////////////////////////////////////////////////
    // Two-flop synchroniser
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= pin_i;
            sync_b <= sync_a;
        end
    end

    // Sample once per period, compare with last sample
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            level_o <= '0;
            prev <= '0;
            rise_o <= '0;
            fall_o <= '0;
        end else if (strobe_i) begin
            prev <= sync_b;
            level_o <= sync_b;
            rise_o <= sync_b & ~prev;
            fall_o <= ~sync_b & prev;
        end else begin
            rise_o <= '0;
            fall_o <= '0;
        end
    end

endmodule // pdio_sampler
`default_nettype wire

/* File: pdio_top.sv */
/*
 * Discrete PLC I/O block: sampled command inputs, relay status outputs
 * and interface settings, reached over an APB slave.
 * Assumes machine state arrives on sys_clk_i, pins are asynchronous.
 */
// Implementation choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

//
// Contract
// - Inputs ignored unless location PLC, all, local+PLC
// - Zero rise enables, fall disables subtraction
// - Start rise issues start command
// - Stop rise stops; long hold vents
// - Purge rise activates, fall deactivates
// - Clear rise acknowledges error
// - Cal rise: standby internal, measuring external
// - Cal fall confirms external calibration
// - Cal-int rise starts internal calibration always
// - Cal-ext rise starts external; fall confirms
// - Trigger relay open when over or idle
// - Zero relay closed while zero runs
// - Ready relay closed measuring, emission, no error
// - Cal-active relay closed during calibration
// - Cal-request relay opens on request
// - Fail/warning relays open while shown
// - Gas ballast closed; constant relays fixed
// - Strobe closed when leak-rate recorder invalid
// - Pump relay open evacuating; vented open venting
// - Standby open standby/vent; emission open emitting
// - Sample period limited 10 to 100 ms
// - Baud 1200-19200; terminator CRLF, CR, LF
// - 7/8 bits, parity, 1/2 stops independent
// - Scaling changes only in lin/log mode
// - PLC-only locks local start/stop/zero
module pdio_top
    import pdio_pkg::*;
#(
    parameter int unsigned MS_CYCLES = MS_CYC // Cycles per millisecond
) (
    input wire logic sys_clk_i,              // System clock, 25 MHz
    input wire logic rstn_i,                 // Sync reset, active low
    input wire logic psel_i,                 // APB select
    input wire logic penable_i,              // APB enable
    input wire logic pwrite_i,               // APB write
    input wire logic [7:0] paddr_i,          // APB byte address
    input wire logic [31:0] pwdata_i,        // APB write data
    output logic [31:0] prdata_o,            // APB read data
    output logic pready_o,                   // APB ready
    output logic pslverr_o,                  // APB error
    input wire logic [NUM_IN-1:0] plc_in_i,  // PLC command pins
    input wire pdio_mach_s mach_i,           // Machine state
    output pdio_cmd_s cmd_o,                 // Commands to machine
    output logic [NUM_RELAY-1:0] relay_o,    // Relay closed when high
    output logic local_lock_o,               // Local buttons locked
    output pdio_ser_s ser_o,                 // Serial framing
    output logic [2:0] rec_fn_o,             // Recorder function
    output logic [2:0] rec_step_o,           // Volts per decade step
    output logic [4:0] rec_decade_o          // Upper decade
);

    ////////////////////////////////////////////////////////////////////
    // Helper functions

    // Input field of one pin
    function automatic pdio_infn_e in_fn(input logic [8:0] map,
                                         input int unsigned idx);
        return pdio_infn_e'(map[idx*IN_FW +: IN_FW]);
    endfunction

    // Any pin assigned to a function with an event on it
    function automatic logic hit(input logic [8:0] map,
                                 input logic [NUM_IN-1:0] ev,
                                 input pdio_infn_e fn);
        logic r;
        r = 1'b0;
        for (int unsigned i = 0; i < NUM_IN; i++) begin
            if (ev[i] && in_fn(map, i) == fn) begin
                r = 1'b1;
            end
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Registers
    logic [2:0] loc;
    logic [6:0] sample_ms;
    logic [15:0] vent_ms;
    logic [8:0] in_map;
    logic [15:0] out_map;
    logic [2:0] rec_fn;
    logic [2:0] rec_step;
    logic [4:0] rec_dec;
    logic zero_act;
    logic purge_act;
    logic ext_wait;
    logic stop_hold;
    logic vent_done;
    logic [15:0] hold_ms;
    logic [15:0] ms_cnt;
    logic [6:0] per_cnt;
    logic ms_tick;
    logic strobe;
    logic [NUM_IN-1:0] lvl;
    logic [NUM_IN-1:0] rise_raw;
    logic [NUM_IN-1:0] fall_raw;
    logic [NUM_IN-1:0] rise;
    logic [NUM_IN-1:0] fall;
    logic accept;
    logic wr_en;
    logic rd_en;
    logic mapped;
    logic [31:0] status;
    logic [NUM_RELAY-1:0] next_relay;
    logic stop_lvl;

    ////////////////////////////////////////////////////////////////////
    // APB decode; always ready, error on unmapped address
    assign wr_en = psel_i & penable_i & pwrite_i & mapped;
    assign rd_en = psel_i & penable_i & ~pwrite_i;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~mapped;

    // Address map check
    always_comb begin
        unique case (paddr_i)
            REG_LOC, REG_SAMPLE, REG_VENT, REG_INMAP,
            REG_OUTMAP, REG_SERIAL, REG_REC, REG_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Location register, values above local-only ignored
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            loc <= LOC_RST;
        end else if (wr_en && paddr_i == REG_LOC
                     && pwdata_i[2:0] <= LOC_LCL) begin
            loc <= pwdata_i[2:0];
        end
    end

    // Sample period, clamped into its legal window
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            sample_ms <= SAMPLE_RST;
        end else if (wr_en && paddr_i == REG_SAMPLE) begin
            if (pwdata_i[31:0] < SAMPLE_MIN_MS) begin
                sample_ms <= 7'(SAMPLE_MIN_MS);
            end else if (pwdata_i[31:0] > SAMPLE_MAX_MS) begin
                sample_ms <= 7'(SAMPLE_MAX_MS);
            end else begin
                sample_ms <= pwdata_i[6:0];
            end
        end
    end

    // Vent delay and pin assignment registers
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            vent_ms <= VENT_RST;
            in_map <= INMAP_RST;
            out_map <= OUTMAP_RST;
        end else if (wr_en) begin
            if (paddr_i == REG_VENT) begin
                vent_ms <= pwdata_i[15:0];
            end
            if (paddr_i == REG_INMAP) begin
                in_map <= pwdata_i[8:0];
            end
            if (paddr_i == REG_OUTMAP) begin
                out_map <= pwdata_i[15:0];
            end
        end
    end

    // Serial framing; illegal codes keep the old field
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ser_o <= SERIAL_RST;
        end else if (wr_en && paddr_i == REG_SERIAL) begin
            if (pwdata_i[8:6] <= BAUD_MAX) begin
                ser_o.baud <= pwdata_i[8:6];
            end
            if (pwdata_i[5:4] <= TERM_MAX) begin
                ser_o.term <= pwdata_i[5:4];
            end
            ser_o.eight_bits <= pwdata_i[3];
            if (pwdata_i[2:1] <= PAR_MAX) begin
                ser_o.parity <= pwdata_i[2:1];
            end
            ser_o.two_stop <= pwdata_i[0];
        end
    end

    // Recorder: scaling writable only with lin or log function
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            rec_fn <= REC_RST[REC_FN_LSB +: 3];
            rec_step <= REC_RST[REC_STEP_LSB +: 3];
            rec_dec <= REC_RST[REC_DEC_LSB +: 5];
        end else if (wr_en && paddr_i == REG_REC) begin
            if (pwdata_i[REC_FN_LSB +: 3] <= REC_LOG) begin
                rec_fn <= pwdata_i[REC_FN_LSB +: 3];
            end
            if (rec_fn == REC_LIN || rec_fn == REC_LOG) begin
                if (pwdata_i[REC_STEP_LSB +: 3] <= STEP_MAX) begin
                    rec_step <= pwdata_i[REC_STEP_LSB +: 3];
                end
                rec_dec <= pwdata_i[REC_DEC_LSB +: 5];
            end
        end
    end

    // Status word
    assign status = {13'h0000, lvl, relay_o, 5'h00,
                     vent_done, stop_hold, ext_wait,
                     purge_act, zero_act, accept, local_lock_o};

    // Read data register
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            unique case (paddr_i)
                REG_LOC: prdata_o <= {29'h0, loc};
                REG_SAMPLE: prdata_o <= {25'h0, sample_ms};
                REG_VENT: prdata_o <= {16'h0, vent_ms};
                REG_INMAP: prdata_o <= {23'h0, in_map};
                REG_OUTMAP: prdata_o <= {16'h0, out_map};
                REG_SERIAL: prdata_o <= {23'h0, ser_o};
                REG_REC: prdata_o <= {21'h0, rec_dec, rec_step, rec_fn};
                REG_STATUS: prdata_o <= status;
                default: prdata_o <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Millisecond tick and sample strobe
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ms_cnt <= 16'h0000;
            ms_tick <= 1'b0;
        end else if (ms_cnt == 16'(MS_CYCLES - 1)) begin
            ms_cnt <= 16'h0000;
            ms_tick <= 1'b1;
        end else begin
            ms_cnt <= ms_cnt + 16'h0001;
            ms_tick <= 1'b0;
        end
    end

    // One strobe per sample period
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            per_cnt <= 7'h00;
            strobe <= 1'b0;
        end else if (ms_tick && per_cnt >= sample_ms - 7'h01) begin
            per_cnt <= 7'h00;
            strobe <= 1'b1;
        end else begin
            if (ms_tick) begin
                per_cnt <= per_cnt + 7'h01;
            end
            strobe <= 1'b0;
        end
    end

    // Pin sampler
    pdio_sampler u_sampler (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .pin_i(plc_in_i),
        .strobe_i(strobe),
        .level_o(lvl),
        .rise_o(rise_raw),
        .fall_o(fall_raw)
    );

    // Location gate on every command edge
    assign accept = (loc == LOC_PLC) || (loc == LOC_ALL)
                    || (loc == LOC_LCL_PLC);
    assign rise = accept ? rise_raw : '0;
    assign fall = accept ? fall_raw : '0;
    assign local_lock_o = (loc == LOC_PLC);

    ////////////////////////////////////////////////////////////////////
    // Zero and purge levels follow their edges
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            zero_act <= 1'b0;
            purge_act <= 1'b0;
        end else begin
            if (hit(in_map, rise, IN_ZERO)) begin
                zero_act <= 1'b1;
            end else if (hit(in_map, fall, IN_ZERO)) begin
                zero_act <= 1'b0;
            end
            if (hit(in_map, rise, IN_PURGE)) begin
                purge_act <= 1'b1;
            end else if (hit(in_map, fall, IN_PURGE)) begin
                purge_act <= 1'b0;
            end
        end
    end

    // Stop pin held level, from any pin assigned to stop
    always_comb begin
        stop_lvl = 1'b0;
        for (int unsigned i = 0; i < NUM_IN; i++) begin
            if (lvl[i] && in_fn(in_map, i) == IN_STOP) begin
                stop_lvl = 1'b1;
            end
        end
    end

    // Stop hold timer, vents once the delay is passed
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            stop_hold <= 1'b0;
            vent_done <= 1'b0;
            hold_ms <= 16'h0000;
        end else if (hit(in_map, rise, IN_STOP)) begin
            stop_hold <= 1'b1;
            vent_done <= 1'b0;
            hold_ms <= 16'h0000;
        end else if (stop_hold) begin
            if (!stop_lvl || !accept) begin
                stop_hold <= 1'b0;
            end else if (hold_ms > vent_ms) begin
                stop_hold <= 1'b0;
                vent_done <= 1'b1;
            end else if (ms_tick) begin
                hold_ms <= hold_ms + 16'h0001;
            end
        end
    end

    // External calibration waits for its confirming fall
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            ext_wait <= 1'b0;
        end else if (cmd_o.cal_ext) begin
            ext_wait <= 1'b1;
        end else if (cmd_o.cal_confirm || cmd_o.cal_int) begin
            ext_wait <= 1'b0;
        end
    end

    // Command pulses and levels
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            cmd_o <= '0;
        end else begin
            cmd_o.start <= hit(in_map, rise, IN_START);
            cmd_o.stop <= hit(in_map, rise, IN_STOP);
            cmd_o.vent <= stop_hold && stop_lvl && accept
                          && hold_ms > vent_ms;
            cmd_o.error_ack <= hit(in_map, rise, IN_CLEAR);
            cmd_o.cal_int <= hit(in_map, rise, IN_CAL_INT)
                || (hit(in_map, rise, IN_CAL)
                    && mach_i.standby);
            cmd_o.cal_ext <= hit(in_map, rise, IN_CAL_EXT)
                || (hit(in_map, rise, IN_CAL)
                    && mach_i.measuring);
            cmd_o.cal_confirm <= ext_wait
                && (hit(in_map, fall, IN_CAL)
                    || hit(in_map, fall, IN_CAL_EXT));
            cmd_o.zero_en <= zero_act;
            cmd_o.purge_en <= purge_act;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Relay state per assigned function; high means closed
    always_comb begin
        for (int unsigned r = 0; r < NUM_RELAY; r++) begin
            unique case (out_map[r*OUT_FW +: OUT_FW])
                OUT_TRIG1: next_relay[r] =
                    !(mach_i.trig1_over || !mach_i.measuring);
                OUT_ZERO: next_relay[r] = zero_act;
                OUT_READY: next_relay[r] = mach_i.measuring
                    && mach_i.emission && !mach_i.error;
                OUT_CAL_ACT: next_relay[r] = mach_i.cal_running
                    || ext_wait;
                OUT_CAL_REQ: next_relay[r] =
                    !(mach_i.cal_request || ext_wait);
                OUT_FAIL: next_relay[r] = !mach_i.error;
                OUT_WARN: next_relay[r] = !mach_i.warning;
                OUT_GASB: next_relay[r] =
                    mach_i.gas_ballast || purge_act;
                OUT_OPEN: next_relay[r] = 1'b0;
                OUT_CLOSE: next_relay[r] = 1'b1;
                OUT_STROBE: next_relay[r] = mach_i.rec_invalid
                    && rec_fn >= REC_MANT;
                OUT_PUMP: next_relay[r] = !mach_i.pumping;
                OUT_STANDBY: next_relay[r] =
                    !(mach_i.standby || mach_i.vent_mode);
                OUT_VENTED: next_relay[r] = !mach_i.vent_mode;
                OUT_EMIS: next_relay[r] = !mach_i.emission;
                default: next_relay[r] = 1'b0;
            endcase
        end
    end

    // Registered relay drive
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            relay_o <= '0;
        end else begin
            relay_o <= next_relay;
        end
    end

    // Recorder settings out
    assign rec_fn_o = rec_fn;
    assign rec_step_o = rec_step;
    assign rec_decade_o = rec_dec;

endmodule // pdio_top
`default_nettype wire

/* File: pdio_monitor.sv */
/* Checker on pdio_top ports: relays, pulses, APB error.
   Assumes the relay map stays at its reset value. */
`timescale 1ns/1ps
`default_nettype none
module pdio_monitor
    import pdio_pkg::*;
(
    input wire logic sys_clk_i, // Clock
    input wire logic rstn_i, // Reset, low
    input wire logic psel_i, // APB select
    input wire logic penable_i, // APB enable
    input wire logic pslverr_o, // APB error
    input wire pdio_mach_s mach_i, // Machine state
    input wire pdio_cmd_s cmd_o, // Commands
    input wire logic [NUM_RELAY-1:0] relay_o // Relays
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);
    a_trig_relay: assert property (##1 relay_o[0] ==
        $past(mach_i.measuring & !mach_i.trig1_over)) else $error("trig");
    a_ready_relay: assert property (##1 relay_o[3] ==
        $past(mach_i.measuring & mach_i.emission & !mach_i.error))
        else $error("ready");
    a_open_relay: assert property (##1 !relay_o[2]) else $error("open");
    a_start_pulse: assert property (cmd_o.start |=> !cmd_o.start)
        else $error("start");
    a_stop_pulse: assert property (cmd_o.stop |=> !cmd_o.stop)
        else $error("stop");
    a_ack_pulse: assert property (cmd_o.error_ack |=> !cmd_o.error_ack)
        else $error("ack");
    a_cal_excl: assert property (!(cmd_o.cal_int & cmd_o.cal_ext))
        else $error("cal");
    a_err_access: assert property (pslverr_o |-> psel_i & penable_i)
        else $error("slverr");
    c_start: cover property (cmd_o.start);
    c_vent: cover property (cmd_o.vent);
    c_confirm: cover property (cmd_o.cal_confirm);
endmodule // pdio_monitor
bind pdio_top pdio_monitor mon (.sys_clk_i, .rstn_i, .psel_i, .penable_i,
    .pslverr_o, .mach_i, .cmd_o, .relay_o);
`default_nettype wire

/* File: pdio_plc_model.sv */
/* PLC partner: drives the command pins.
   Assumes the bench calls set_pin to move one pin after an edge. */
`timescale 1ns/1ps
`default_nettype none
module pdio_plc_model (
    input wire logic clk_i, // Clock
    output logic [2:0] pin_o // Command pins
);
    initial pin_o = 3'h0;
    // Pin changes just after an edge
    task automatic set_pin(input int i, input logic v);
        @(posedge clk_i);
        pin_o[i] <= v;
    endtask
endmodule // pdio_plc_model
`default_nettype wire

/* File: testbench.sv */
/* Testbench: APB master, PLC partner, pulse-counting model.
   Assumes MS_CYCLES of 4, so a sample period is 40 cycles. */
`timescale 1ns/1ps
`default_nettype none
module testbench import pdio_pkg::*;;
    logic clk = 0, rstn = 0, psel = 0, pen = 0, pw = 0, rdy, err, er, lock;
    logic [7:0] pa = 0;
    logic [31:0] pwd = 0, prd, rd, seed = 32'h50;
    logic [2:0] pins;
    logic [3:0] rel;
    pdio_mach_s mach = '0;
    pdio_cmd_s cmd;
    pdio_ser_s ser;
    int failures = 0, num_checks = 0, cyc = 0, cnt[9] = '{default:0};
    int exp[9] = '{default:0};
    pdio_top #(.MS_CYCLES(4)) dut (.sys_clk_i(clk), .rstn_i(rstn),
        .psel_i(psel), .penable_i(pen), .pwrite_i(pw), .paddr_i(pa),
        .pwdata_i(pwd), .prdata_o(prd), .pready_o(rdy), .pslverr_o(err),
        .plc_in_i(pins), .mach_i(mach), .cmd_o(cmd), .relay_o(rel),
        .local_lock_o(lock), .ser_o(ser), .rec_fn_o(), .rec_step_o(),
        .rec_decade_o());
    pdio_plc_model plc (.clk_i(clk), .pin_o(pins));
    // Clock
    initial forever #20 clk = ~clk;
    // Pulse counts and hang guard
    always @(posedge clk) begin
        for (int i = 0; i < 9; i++) cnt[i] += cmd[i];
        cyc++;
        if (cyc == 10000) begin
            failures++;
            summarize;
        end
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            failures++;
            $display("mismatch %0t seen %h exp %h", $time, s, e);
        end
    endtask
    task cmp;
        for (int i = 2; i < 9; i++) chk(cnt[i], exp[i]);
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pw, pa, pwd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        er = err;
        {psel, pen} <= 2'b00;
        @(posedge clk);
    endtask
    task pin(input int i, input logic v);
        plc.set_pin(i, v);
        repeat (100) @(posedge clk);
    endtask
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    task summarize;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1;
        apb(1, REG_SAMPLE, 32'h5);
        apb(0, REG_SAMPLE, 0);
        chk(rd, 32'h0A);
        apb(0, 8'h20, 0);
        chk(er, 1);
        apb(1, REG_SERIAL, 32'h1FF);
        chk(ser, 32'h0D);
        apb(1, REG_REC, 32'h119);
        apb(1, REG_REC, 32'h0A);
        apb(0, REG_REC, 0);
        chk(rd, 32'h11A);
        pin(0, 1);
        pin(0, 0);
        cmp;
        apb(1, REG_LOC, 0);
        chk(lock, 1);
        pin(0, 1);
        pin(0, 0);
        exp[8]++;
        pin(1, 1);
        pin(1, 0);
        exp[7]++;
        apb(1, REG_VENT, 2);
        pin(1, 1);
        pin(1, 1);
        pin(1, 0);
        exp[7]++;
        exp[6]++;
        cmp;
        apb(1, REG_INMAP, 32'h151);
        mach.standby <= 1;
        pin(2, 1);
        pin(2, 0);
        mach <= 12'h800;
        pin(2, 1);
        pin(2, 0);
        exp[4]++;
        exp[3]++;
        exp[2]++;
        cmp;
        apb(1, REG_INMAP, 32'h118);
        for (int i = 0; i < 2; i++) begin
            pin(i, 1);
            chk(cmd[1 - i], 1);
            pin(i, 0);
            chk(cmd[1 - i], 0);
        end
        pin(2, 1);
        pin(2, 0);
        exp[5]++;
        apb(1, REG_INMAP, 32'hBE);
        pin(0, 1);
        pin(1, 1);
        pin(1, 0);
        exp[4]++;
        exp[3]++;
        exp[2]++;
        cmp;
        repeat (20) begin
            seed = xs(seed);
            mach <= seed[11:0];
            repeat (3) @(posedge clk);
            chk(rel, {mach.measuring & mach.emission & !mach.error, 2'b00,
                mach.measuring & !mach.trig1_over} & 4'hD);
        end
        summarize;
    end
endmodule // testbench
`default_nettype wire
